// file: include/node_id_consts.svh
// Offsets, field positions, reset values and timing counts for the node identity register bank
`ifndef NODE_ID_CONSTS_SVH
`define NODE_ID_CONSTS_SVH

`define OFS_UID_UPPER      12'h024
`define OFS_UID_LOWER      12'h028
`define OFS_ROM_BASE       12'h034
`define OFS_FAIL_LOW       12'h038
`define OFS_IRQ_STATUS     12'h060
`define OFS_IRQ_MASK       12'h064
`define OFS_ROM_STATUS     12'h068

`define UID_RESET          32'h0000_0000
`define ROM_BASE_RESET     32'h0000_0000
`define FAIL_LOW_RESET     32'h0000_0000
`define ROM_BASE_LSB       10
`define ROM_BASE_RO_MASK   32'hFFFF_FC00
`define ROM_WIN_LO         48'hFFFF_F000_0400
`define ROM_WIN_HI         48'hFFFF_F000_07FF

`define IRQ_BIT_LOADED     0
`define IRQ_BIT_POSTFAIL   1
`define IRQ_BIT_ROMREAD    2
`define IRQ_WIDTH          3

`define SROM_WORDS         8
`define SROM_WAIT_CYCLES   4
`define CLK_PERIOD_NS      40

`endif

// file: include/node_id_pkg.sv
// Types shared by the node identity register bank
`default_nettype none
package node_id_pkg;

  typedef enum logic [2:0] {
    LD_IDLE  = 3'b000,
    LD_REQ   = 3'b001,
    LD_WAIT  = 3'b010,
    LD_STORE = 3'b011,
    LD_DONE  = 3'b100
  } load_state_t;

  typedef struct packed {
    logic        valid;
    logic [47:0] offset;
  } rom_read_req_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [31:0] host_addr;
  } rom_read_rsp_t;

  typedef struct packed {
    logic        fail;
    logic [47:0] offset;
  } post_fail_t;

endpackage : node_id_pkg
`default_nettype wire

// file: hdl/sticky_bit.sv
// One sticky status bit, set by an event, cleared by writing one
`default_nettype none
module sticky_bit (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output logic      flag
);
  logic flag_ff;
  logic nxt_flag;

  // Set beats clear so an event in the clear cycle is kept
  always_comb begin
    nxt_flag = set_evt ? 1'b1 : (clr_req ? 1'b0 : flag_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;
endmodule : sticky_bit
`default_nettype wire

// file: hdl/rom_map_calc.sv
// Config ROM window decode and host address forming
`include "node_id_consts.svh"
`default_nettype none
module rom_map_calc (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire node_id_pkg::rom_read_req_t req,
  input  wire logic [31:0]            base,
  output node_id_pkg::rom_read_rsp_t  rsp
);
  node_id_pkg::rom_read_rsp_t rsp_ff;
  node_id_pkg::rom_read_rsp_t nxt_rsp;
  logic                       in_win;

  always_comb begin
    in_win            = (req.offset >= `ROM_WIN_LO) && (req.offset <= `ROM_WIN_HI);
    nxt_rsp.valid     = req.valid;
    nxt_rsp.hit       = req.valid && in_win;
    // Base low bits are zero, so the add never carries past bit 10
    nxt_rsp.host_addr = (req.valid && in_win) ? (base + {22'h00_0000, req.offset[9:0]}) : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign rsp = rsp_ff;

  property p_map_add;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && req.offset >= `ROM_WIN_LO && req.offset <= `ROM_WIN_HI) |=>
        (rsp.hit && rsp.host_addr == $past(base) + {22'h00_0000, $past(req.offset[9:0])});
  endproperty
  a_map_add: assert property (p_map_add) else $error("rom map address wrong");

  property p_map_miss;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && req.offset < `ROM_WIN_LO) |=> (rsp.valid && !rsp.hit);
  endproperty
  a_map_miss: assert property (p_map_miss) else $error("rom map hit outside window");
endmodule : rom_map_calc
`default_nettype wire

// file: hdl/node_id_regs.sv
// APB register bank for node unique id, config ROM map base and posted write fail capture
//
// The APB slave port was left to the implementer.
`include "node_id_consts.svh"
`default_nettype none
module node_id_regs (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       pci_reset_done,
  input  wire logic                       srom_present,
  output logic                            srom_rd_req,
  output logic [2:0]                      srom_rd_addr,
  input  wire logic                       srom_rd_ack,
  input  wire logic [7:0]                 srom_rd_data,
  input  wire node_id_pkg::rom_read_req_t rom_req,
  output node_id_pkg::rom_read_rsp_t      rom_rsp,
  input  wire node_id_pkg::post_fail_t    post_fail,
  output logic [63:0]                     unique_id,
  output logic                            irq
);
  logic [31:0]               uid_upper_ff;
  logic [31:0]               nxt_uid_upper;
  logic [31:0]               uid_lower_ff;
  logic [31:0]               nxt_uid_lower;
  logic                      locked_ff;
  logic                      nxt_locked;
  node_id_pkg::load_state_t  ld_state_ff;
  node_id_pkg::load_state_t  nxt_ld_state;
  logic [2:0]                byte_idx_ff;
  logic [2:0]                nxt_byte_idx;
  logic [7:0]                byte_ff;
  logic [7:0]                nxt_byte;
  logic [31:0]               rom_base_ff;
  logic [31:0]               nxt_rom_base;
  logic [31:0]               fail_low_ff;
  logic [31:0]               nxt_fail_low;
  logic [`IRQ_WIDTH-1:0]     mask_ff;
  logic [`IRQ_WIDTH-1:0]     nxt_mask;
  logic [`IRQ_WIDTH-1:0]     status;
  logic [`IRQ_WIDTH-1:0]     evt;
  logic [`IRQ_WIDTH-1:0]     clr;
  logic [31:0]               rdata;
  logic [31:0]               prdata_ff;
  logic [31:0]               nxt_prdata;
  logic                      wr_acc;
  logic                      rd_acc;
  logic                      mapped;
  logic                      load_done;

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign pready  = 1'b1;

  // Serial ROM loader: eight bytes, upper quadlet first, MSB first
  always_comb begin
    nxt_ld_state  = ld_state_ff;
    nxt_byte_idx  = byte_idx_ff;
    nxt_byte      = byte_ff;
    nxt_uid_upper = uid_upper_ff;
    nxt_uid_lower = uid_lower_ff;
    nxt_locked    = locked_ff;
    load_done     = 1'b0;
    case (ld_state_ff)
      node_id_pkg::LD_IDLE: begin
        if (pci_reset_done && srom_present && !locked_ff) begin
          nxt_byte_idx = 3'd0;
          nxt_ld_state = node_id_pkg::LD_REQ;
        end
      end
      node_id_pkg::LD_REQ: begin
        nxt_ld_state = node_id_pkg::LD_WAIT;
      end
      node_id_pkg::LD_WAIT: begin
        if (srom_rd_ack) begin
          nxt_byte     = srom_rd_data;
          nxt_ld_state = node_id_pkg::LD_STORE;
        end
      end
      node_id_pkg::LD_STORE: begin
        if (byte_idx_ff[2] == 1'b0) begin
          nxt_uid_upper = {uid_upper_ff[23:0], byte_ff};
        end else begin
          nxt_uid_lower = {uid_lower_ff[23:0], byte_ff};
        end
        if (byte_idx_ff == 3'd7) begin
          nxt_locked   = 1'b1;
          load_done    = 1'b1;
          nxt_ld_state = node_id_pkg::LD_DONE;
        end else begin
          nxt_byte_idx = byte_idx_ff + 3'd1;
          nxt_ld_state = node_id_pkg::LD_REQ;
        end
      end
      node_id_pkg::LD_DONE: begin
        // Locked for good; only hardware reset reopens the load
        nxt_ld_state = node_id_pkg::LD_DONE;
      end
      default: begin
        nxt_ld_state = node_id_pkg::LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state_ff  <= node_id_pkg::LD_IDLE;
      byte_idx_ff  <= 3'd0;
      byte_ff      <= 8'h00;
      uid_upper_ff <= `UID_RESET;
      uid_lower_ff <= `UID_RESET;
      locked_ff    <= 1'b0;
    end else begin
      ld_state_ff  <= nxt_ld_state;
      byte_idx_ff  <= nxt_byte_idx;
      byte_ff      <= nxt_byte;
      uid_upper_ff <= nxt_uid_upper;
      uid_lower_ff <= nxt_uid_lower;
      locked_ff    <= nxt_locked;
    end
  end

  assign srom_rd_req  = (ld_state_ff == node_id_pkg::LD_REQ);
  assign srom_rd_addr = byte_idx_ff;
  // Upper quadlet feeds the third bus info block quadlet
  assign unique_id    = {uid_upper_ff, uid_lower_ff};

  // Map base, fail capture and mask registers
  always_comb begin
    nxt_rom_base = rom_base_ff;
    nxt_fail_low = fail_low_ff;
    nxt_mask     = mask_ff;
    if (wr_acc && paddr == `OFS_ROM_BASE) begin
      nxt_rom_base = pwdata & `ROM_BASE_RO_MASK;
    end
    if (wr_acc && paddr == `OFS_IRQ_MASK) begin
      nxt_mask = pwdata[`IRQ_WIDTH-1:0];
    end
    // Only a fresh failure overwrites; software writes are ignored
    if (post_fail.fail) begin
      nxt_fail_low = post_fail.offset[31:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_base_ff <= `ROM_BASE_RESET;
      fail_low_ff <= `FAIL_LOW_RESET;
      mask_ff     <= '0;
    end else begin
      rom_base_ff <= nxt_rom_base;
      fail_low_ff <= nxt_fail_low;
      mask_ff     <= nxt_mask;
    end
  end

  rom_map_calc u_map (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (rom_req),
    .base    (rom_base_ff),
    .rsp     (rom_rsp)
  );

  // Interrupt status: write one to clear
  assign evt[`IRQ_BIT_LOADED]   = load_done;
  assign evt[`IRQ_BIT_POSTFAIL] = post_fail.fail;
  assign evt[`IRQ_BIT_ROMREAD]  = rom_req.valid;
  assign clr = (wr_acc && paddr == `OFS_IRQ_STATUS) ? pwdata[`IRQ_WIDTH-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_sticky
      sticky_bit u_bit (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (evt[gi]),
        .clr_req (clr[gi]),
        .flag    (status[gi])
      );
    end
  endgenerate

  assign irq = |(status & mask_ff);

  // Read mux
  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `OFS_UID_UPPER:  rdata = uid_upper_ff;
      `OFS_UID_LOWER:  rdata = uid_lower_ff;
      `OFS_ROM_BASE:   rdata = rom_base_ff & `ROM_BASE_RO_MASK;
      `OFS_FAIL_LOW:   rdata = fail_low_ff;
      `OFS_IRQ_STATUS: rdata = {29'h0000_0000, status};
      `OFS_IRQ_MASK:   rdata = {29'h0000_0000, mask_ff};
      `OFS_ROM_STATUS: rdata = {30'h0000_0000, srom_present, locked_ff};
      default:         mapped = 1'b0;
    endcase
  end

  // Captured in the setup phase: flopped read data with no wait state
  always_comb begin
    nxt_prdata = (psel && !penable && !pwrite) ? rdata : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata  = prdata_ff;
  assign pslverr = psel && penable && !mapped;

  property p_id_frozen;
    @(posedge pclk) disable iff (!presetn)
      locked_ff |=> ($stable(uid_upper_ff) && $stable(uid_lower_ff) && locked_ff);
  endproperty
  a_id_frozen: assert property (p_id_frozen) else $error("id changed after lock");

  property p_id_wr_ignored;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `OFS_UID_UPPER && ld_state_ff != node_id_pkg::LD_STORE) |=> $stable(uid_upper_ff);
  endproperty
  a_id_wr_ignored: assert property (p_id_wr_ignored) else $error("id register took a bus write");

  property p_zero_until_load;
    @(posedge pclk) disable iff (!presetn)
      (ld_state_ff == node_id_pkg::LD_IDLE) |-> (uid_upper_ff == `UID_RESET && uid_lower_ff == `UID_RESET);
  endproperty
  a_zero_until_load: assert property (p_zero_until_load) else $error("id not zero before load");

  sequence s_load_start;
    ld_state_ff == node_id_pkg::LD_IDLE && pci_reset_done && srom_present;
  endsequence
  sequence s_first_req;
    ##1 srom_rd_req && srom_rd_addr == 3'd0;
  endsequence
  property p_load_start;
    @(posedge pclk) disable iff (!presetn) s_load_start |-> s_first_req;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load did not start");

  property p_lower_load;
    @(posedge pclk) disable iff (!presetn)
      (ld_state_ff == node_id_pkg::LD_STORE && byte_idx_ff == 3'd7) |=>
        (uid_lower_ff[7:0] == $past(byte_ff) && locked_ff);
  endproperty
  a_lower_load: assert property (p_lower_load) else $error("lower id last byte wrong");

  property p_base_low_zero;
    @(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == `OFS_ROM_BASE) |-> (prdata[9:0] == 10'h000);
  endproperty
  a_base_low_zero: assert property (p_base_low_zero) else $error("map base low bits not zero");

  property p_fail_capture;
    @(posedge pclk) disable iff (!presetn)
      post_fail.fail |=> (fail_low_ff == $past(post_fail.offset[31:0]));
  endproperty
  a_fail_capture: assert property (p_fail_capture) else $error("failed offset not captured");

  property p_fail_hold;
    @(posedge pclk) disable iff (!presetn)
      !post_fail.fail |=> $stable(fail_low_ff);
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("failed offset changed without failure");

  property p_base_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `OFS_ROM_BASE) |=>
        (rom_base_ff[9:0] == 10'h000 && rom_base_ff[31:10] == $past(pwdata[31:10]));
  endproperty
  a_base_write: assert property (p_base_write) else $error("map base write not taken");

  property p_no_rom_idle;
    @(posedge pclk) disable iff (!presetn)
      (ld_state_ff == node_id_pkg::LD_IDLE && !srom_present) |=>
        (ld_state_ff == node_id_pkg::LD_IDLE && !srom_rd_req);
  endproperty
  a_no_rom_idle: assert property (p_no_rom_idle) else $error("loader ran without serial rom");

  property p_upper_load;
    @(posedge pclk) disable iff (!presetn)
      (ld_state_ff == node_id_pkg::LD_STORE && byte_idx_ff == 3'h3) |=> (uid_upper_ff[7:0] == $past(byte_ff));
  endproperty
  a_upper_load: assert property (p_upper_load) else $error("upper id last byte wrong");

  property p_lower_read;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == `OFS_UID_LOWER) |=> (prdata == $past(uid_lower_ff));
  endproperty
  a_lower_read: assert property (p_lower_read) else $error("lower id read data wrong");
endmodule : node_id_regs
`default_nettype wire

// file: dv/srom_model.sv
// Serial ROM byte port model, prompt or slow
`default_nettype none
module srom_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic [63:0] contents,
  input  wire logic        srom_rd_req,
  input  wire logic [2:0]  srom_rd_addr,
  output logic             srom_rd_ack,
  output logic [7:0]       srom_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_ff;
  logic [2:0] addr_ff;
  logic [1:0] wait_ff;
  logic [7:0] last_ff;
  // Idle data is inverted so a stale byte never passes for a fresh one
  assign srom_rd_data = srom_rd_ack ? last_ff : ~last_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      addr_ff <= 3'h0;
      wait_ff <= 2'h0;
      last_ff <= 8'h00;
      srom_rd_ack <= 1'b0;
    end else begin
      srom_rd_ack <= 1'b0;
      if (srom_rd_req) begin
        busy_ff <= 1'b1;
        addr_ff <= srom_rd_addr;
        wait_ff <= slow ? 2'h3 : 2'h0;
      end else if (busy_ff && wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else if (busy_ff) begin
        busy_ff <= 1'b0;
        srom_rd_ack <= 1'b1;
        last_ff <= contents[63 - 8 * addr_ff -: 8];
      end
    end
  end
endmodule : srom_model
`default_nettype wire

// file: dv/test_node_id_and_rom_map_regs.sv
// Self-checking bench for the node id and config ROM map register bank
`include "node_id_consts.svh"
`default_nettype none
module test_node_id_and_rom_map_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pci_done = 1'b0;
  logic        present = 1'b0;
  logic        slow = 1'b1;
  logic [63:0] contents = 64'h0;
  logic        rd_req;
  logic [2:0]  rd_addr;
  logic        rd_ack;
  logic [7:0]  rd_data;
  logic [63:0] unique_id;
  logic        irq;
  node_id_pkg::rom_read_req_t rom_req = '0;
  node_id_pkg::rom_read_rsp_t rom_rsp;
  node_id_pkg::post_fail_t    post_fail = '0;
  int          mismatches = 0;
  int          check_count = 0;
  int          seed = 48;
  logic [31:0] rd;
  logic        err;
  logic [31:0] base;
  logic [47:0] offs [5];
  logic [63:0] id_exp;
  always #20 pclk = ~pclk;
  node_id_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pci_reset_done(pci_done), .srom_present(present), .srom_rd_req(rd_req), .srom_rd_addr(rd_addr),
    .srom_rd_ack(rd_ack), .srom_rd_data(rd_data), .rom_req(rom_req), .rom_rsp(rom_rsp),
    .post_fail(post_fail), .unique_id(unique_id), .irq(irq));
  srom_model u_srom (.pclk(pclk), .presetn(presetn), .slow(slow), .contents(contents),
    .srom_rd_req(rd_req), .srom_rd_addr(rd_addr), .srom_rd_ack(rd_ack), .srom_rd_data(rd_data));
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [63:0] seen, input logic [63:0] expv);
    check_count++;
    if (seen !== expv) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, expv);
    end
  endtask : chk
  // Starts one edge after the last release, so no signal is driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      results();
    end
  endtask : apb
  function automatic node_id_pkg::rom_read_rsp_t exp_map(input logic [31:0] b, input logic [47:0] o);
    exp_map.valid = 1'b1;
    exp_map.hit = (o >= `ROM_WIN_LO) && (o <= `ROM_WIN_HI);
    exp_map.host_addr = exp_map.hit ? b + {22'h0, o[9:0]} : 32'h0;
  endfunction : exp_map
  // Bounded wait for the id loaded interrupt; running out counts as a mismatch
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (irq !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask : wait_irq
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_UID_UPPER, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFS_UID_LOWER, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, `OFS_ROM_BASE, 32'hFFFF_FFFF);
    apb(1'b0, `OFS_ROM_BASE, 32'h0);
    chk(rd, 32'hFFFF_FC00);
    base = $random(seed);
    apb(1'b1, `OFS_ROM_BASE, base);
    base = base & `ROM_BASE_RO_MASK;
    apb(1'b0, `OFS_ROM_BASE, 32'h0);
    chk(rd, base);
    offs = '{`ROM_WIN_LO - 48'h1, `ROM_WIN_LO, `ROM_WIN_LO + {38'h0, 10'($random(seed)) & 10'h3FF},
             `ROM_WIN_HI, `ROM_WIN_HI + 48'h1};
    foreach (offs[i]) begin
      @(posedge pclk);
      rom_req <= '{valid: 1'b1, offset: offs[i]};
      @(posedge pclk);
      rom_req <= '0;
      @(posedge pclk);
      chk(rom_rsp, exp_map(base, offs[i]));
    end
    apb(1'b1, `OFS_IRQ_STATUS, 32'h7);
    repeat (2) begin
      offs[0] = 48'({$random(seed), $random(seed)});
      @(posedge pclk);
      post_fail <= '{fail: 1'b1, offset: offs[0]};
      @(posedge pclk);
      post_fail <= '0;
      repeat (3) @(posedge pclk);
      apb(1'b0, `OFS_FAIL_LOW, 32'h0);
      chk(rd, offs[0][31:0]);
      apb(1'b1, `OFS_FAIL_LOW, 32'hFFFF_FFFF);
      apb(1'b0, `OFS_FAIL_LOW, 32'h0);
      chk(rd, offs[0][31:0]);
    end
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk({irq, rd}, {1'b0, 32'h2});
    apb(1'b1, `OFS_IRQ_STATUS, 32'h2);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    id_exp = {$random(seed), $random(seed)};
    contents <= id_exp;
    present <= 1'b1;
    pci_done <= 1'b1;
    wait_irq();
    chk(unique_id, id_exp);
    apb(1'b0, `OFS_UID_UPPER, 32'h0);
    chk(rd, id_exp[63:32]);
    apb(1'b0, `OFS_UID_LOWER, 32'h0);
    chk(rd, id_exp[31:0]);
    apb(1'b0, `OFS_ROM_STATUS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk({irq, rd}, {1'b0, 32'h0});
    slow <= 1'b0;
    contents <= ~id_exp;
    pci_done <= 1'b0;
    apb(1'b1, `OFS_UID_UPPER, 32'hFFFF_FFFF);
    pci_done <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(unique_id, id_exp);
    apb(1'b0, `OFS_UID_UPPER, 32'h0);
    chk(rd, id_exp[63:32]);
    // Mid-run reset: ids clear and the lock opens, then a prompt ROM reloads
    @(posedge pclk);
    presetn <= 1'b0;
    pci_done <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(unique_id, 64'h0);
    presetn <= 1'b1;
    apb(1'b0, `OFS_ROM_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    pci_done <= 1'b1;
    wait_irq();
    chk(unique_id, contents);
    apb(1'b0, `OFS_UID_LOWER, 32'h0);
    chk(rd, contents[31:0]);
    results();
  end
endmodule : test_node_id_and_rom_map_regs
`default_nettype wire
